// file: core/epprf_pkg.sv
// shared constants and types for the printer port register and fifo block
package epprf_pkg;

  localparam logic [10:0] OFF_DATA = 11'h000;
  localparam logic [10:0] OFF_STATUS = 11'h001;
  localparam logic [10:0] OFF_CONTROL = 11'h002;
  localparam logic [10:0] OFF_QUEUE = 11'h400;
  localparam logic [10:0] OFF_RESSEL = 11'h401;
  localparam logic [10:0] OFF_EXTCTL = 11'h402;

  localparam logic [2:0] MODE_SPP = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_RSVD = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;

  localparam int CB_DIR = 5;
  localparam int CB_IRQEN = 4;
  localparam int CB_SEL = 3;
  localparam int CB_INIT = 2;
  localparam int CB_LF = 1;
  localparam int CB_STB = 0;

  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic ERRDIS_RESET = 1'b1;
  localparam logic SVC_RESET = 1'b1;
  localparam logic [7:0] CAPABILITY = 8'h10;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_FULL = 5'h10;

  localparam int CLK_NS = 5;
  localparam int T_SETUP_NS = 500;
  localparam int T_PULSE_NS = 500;
  localparam logic [7:0] CYC_SETUP = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CYC_PULSE = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SETUP = 6'b000010,
    S_PULSE = 6'b000100,
    S_WAIT_HI = 6'b001000,
    S_WAIT_LO = 6'b010000,
    S_REV_HI = 6'b100000
  } epprf_fsm_type;

  typedef struct packed {
    logic cs_n;
    logic aen;
    logic a10;
    logic [2:0] addr;
    logic iow_n;
    logic ior_n;
    logic [7:0] db;
  } epprf_host_type;

  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out_in;
    logic printer_online_in;
    logic fault_n;
    logic [7:0] pd;
  } epprf_cable_in_type;

  typedef struct packed {
    logic [7:0] pd_out;
    logic pd_oe;
    logic strobe_n;
    logic strobe_oe;
    logic line_feed_out;
    logic line_feed_oe;
    logic init_n;
    logic init_oe;
    logic printer_select_out;
    logic select_oe;
  } epprf_cable_out_type;

  localparam epprf_cable_out_type CO_RESET = '{
    pd_out: 8'h00, pd_oe: 1'b1, strobe_n: 1'b1, strobe_oe: 1'b0,
    line_feed_out: 1'b1, line_feed_oe: 1'b0, init_n: 1'b0,
    init_oe: 1'b1, printer_select_out: 1'b1, select_oe: 1'b0};

endpackage

// file: core/epprf_port.sv
// register set, shared fifo and transfer engine of the printer port
`timescale 1ns/1ps

// Notes on behaviour
// - status at 01H, low three bits zero
// - status bits 3..6 show live cable inputs
// - status bit 7 is inverted busy
// - control bits 5:0 reset zero, 7:6 zero
// - modes 000/010 always drive data out
// - interrupt on done-strobe rise when enabled
// - select bit drives select output inverted
// - init bit drives reset output unchanged
// - line feed and strobe bits drive inverted, except lines the 010/011 engine drives
// - mode 010 sends queue bytes, compat handshake
// - mode 011 sends or receives by ecp
// - command and data writes share one queue
// - test mode moves queue, no cable handshake
// - test queue never stalls, flags stay true
// - test reads take oldest byte, repeat last taken when empty
// - service flag sets at thresholds by direction
// - capability register always reads 10H
// - resource bit 7 reads zero
// - resource bit 6 shows irq line level
// - resource bits 2:0 encode dma channel
// - extended control at 402H, bits 7:5 mode
// - mode 000 resets queue, open-collector controls
// - mode 001 direction tri-states, reads pins
// - mode 111 opens config registers at 400H/401H
// - all queue views share sixteen bytes
module epprf_port #(
  parameter logic [4:0] FREE_SPACE_LEVEL = 5'h08,
  parameter logic [4:0] FILL_LEVEL_TRIGGER = 5'h08
) (
  input wire logic clk,
  input wire logic rst_n,
  input epprf_pkg::epprf_host_type host,
  input wire logic irq_line_in,
  output logic [7:0] db_out,
  output logic db_oe,
  output logic irq_out,
  input epprf_pkg::epprf_cable_in_type cable_in,
  output epprf_pkg::epprf_cable_out_type cable_out
);
  import epprf_pkg::*;

  typedef struct packed {
    epprf_host_type host_s1;
    epprf_host_type host_s2;
    epprf_cable_in_type cab_s1;
    epprf_cable_in_type cab_s2;
    logic irq_s1;
    logic irq_s2;
    logic wr_prev;
    logic rd_prev;
    logic [10:0] woff;
    logic [7:0] wdat;
    logic [10:0] roff;
    logic ack_prev;
    logic [5:0] ctrl;
    logic [7:0] data;
    logic [2:0] mode;
    logic err_dis;
    logic dma_en;
    logic svc;
    logic [2:0] irqsel;
    logic [2:0] dmasel;
    logic [FIFO_DEPTH-1:0][8:0] mem;
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [4:0] cnt;
    logic [7:0] last;
    epprf_fsm_type fsm;
    logic [7:0] tmr;
    logic [8:0] byte_q;
    logic [7:0] db_out;
    logic irq;
    epprf_cable_out_type co;
  } epprf_state_type;

  epprf_state_type q;
  epprf_state_type n;

  function automatic logic [2:0] dma_code(input logic [2:0] w);
    unique case (w)
      3'h3, 3'h2, 3'h1: dma_code = w;
      default: dma_code = 3'h0;
    endcase
  endfunction

  function automatic logic [10:0] host_off(input epprf_host_type h);
    host_off = {h.a10, 7'h00, h.addr};
  endfunction

  function automatic logic q_empty(input logic [4:0] c);
    q_empty = (c == 5'h00);
  endfunction

  function automatic logic q_full(input logic [4:0] c);
    q_full = (c == FIFO_FULL);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // host decode
  logic sel;
  logic wr;
  logic rd;
  logic dir;
  logic eng_fwd;
  logic eng_rev;
  logic [7:0] head;
  logic [7:0] rmux;

  always_comb begin
    sel = ~q.host_s2.cs_n & ~q.host_s2.aen;
    wr = sel & ~q.host_s2.iow_n;
    rd = sel & ~q.host_s2.ior_n;
    dir = q.ctrl[CB_DIR];
    eng_fwd = (q.mode == MODE_FIFO) | ((q.mode == MODE_ECP) & ~dir);
    eng_rev = (q.mode == MODE_ECP) & dir;
    // empty queue repeats the last byte taken
    head = !q_empty(q.cnt) ? q.mem[q.rp][7:0] : q.last;
    rmux = 8'h00;
    unique case (host_off(q.host_s2))
      OFF_DATA: begin
        if (q.mode == MODE_BIDIR) begin
          rmux = q.cab_s2.pd;
        end else if (q.mode == MODE_SPP) begin
          rmux = q.data;
        end
      end
      OFF_STATUS: begin
        rmux = {~q.cab_s2.busy, q.cab_s2.ack_n, q.cab_s2.paper_out_in,
                q.cab_s2.printer_online_in, q.cab_s2.fault_n, 3'h0};
      end
      OFF_CONTROL: rmux = {2'h0, q.ctrl};
      OFF_QUEUE: begin
        if (q.mode == MODE_CFG) begin
          rmux = CAPABILITY;
        end else if (q.mode == MODE_TEST || eng_rev) begin
          rmux = head;
        end
      end
      OFF_RESSEL: begin
        if (q.mode == MODE_CFG) begin
          rmux = {1'b0, q.irq_s2, q.irqsel, q.dmasel};
        end
      end
      OFF_EXTCTL: begin
        rmux = {q.mode, q.err_dis, q.dma_en, q.svc,
                q_full(q.cnt), q_empty(q.cnt)};
      end
      default: rmux = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // bus and cable outputs
  assign db_out = q.db_out;
  assign db_oe = rd;
  assign irq_out = q.irq;
  assign cable_out = q.co;

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic push;
    logic pop;
    logic [8:0] pdat;
    logic wr_end;
    logic rd_end;
    logic [4:0] free;
    logic drive;
    push = 1'b0;
    pop = 1'b0;
    pdat = 9'h000;
    wr_end = q.wr_prev & ~wr;
    rd_end = q.rd_prev & ~rd;
    free = FIFO_FULL - q.cnt;
    drive = 1'b0;
    n = q;

    // every pin input passes two flops
    n.host_s1 = host;
    n.host_s2 = q.host_s1;
    n.cab_s1 = cable_in;
    n.cab_s2 = q.cab_s1;
    n.irq_s1 = irq_line_in;
    n.irq_s2 = q.irq_s1;
    n.wr_prev = wr;
    n.rd_prev = rd;
    n.ack_prev = q.cab_s2.ack_n;
    if (wr) begin
      n.woff = host_off(q.host_s2);
      n.wdat = q.host_s2.db;
    end
    if (rd) begin
      n.roff = host_off(q.host_s2);
      n.db_out = rmux;
    end

    // done-strobe rise raises a one-cycle request
    n.irq = q.ctrl[CB_IRQEN] & q.cab_s2.ack_n & ~q.ack_prev;

    // register writes take effect at the end of the strobe
    if (wr_end) begin
      unique case (q.woff)
        OFF_DATA: begin
          if (q.mode == MODE_SPP || q.mode == MODE_BIDIR) begin
            n.data = q.wdat;
          end else if (q.mode == MODE_ECP && !dir) begin
            // address writes carry the command tag
            push = 1'b1;
            pdat = {1'b1, q.wdat};
          end
        end
        OFF_CONTROL: n.ctrl = q.wdat[5:0];
        OFF_QUEUE: begin
          if (eng_fwd || q.mode == MODE_TEST) begin
            push = 1'b1;
            pdat = {1'b0, q.wdat};
          end
        end
        OFF_RESSEL: begin
          if (q.mode == MODE_CFG) begin
            n.irqsel = q.wdat[5:3];
            n.dmasel = dma_code(q.wdat[2:0]);
          end
        end
        OFF_EXTCTL: begin
          n.mode = q.wdat[7:5];
          n.err_dis = q.wdat[4];
          n.dma_en = q.wdat[3];
          n.svc = q.wdat[2];
        end
        default: n.ctrl = q.ctrl;
      endcase
    end

    // host reads pop at the end of the strobe
    // an empty queue is never popped
    if (rd_end && q.roff == OFF_QUEUE && !q_empty(q.cnt) &&
        (q.mode == MODE_TEST || eng_rev)) begin
      pop = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////
    // transfer engine
    if (!(eng_fwd || eng_rev)) begin
      n.fsm = S_IDLE;
      n.tmr = 8'h00;
    end else begin
      unique case (q.fsm)
        S_IDLE: begin
          if (eng_fwd && !q_empty(q.cnt) && !q.cab_s2.busy && !pop) begin
            pop = 1'b1;
            n.byte_q = q.mem[q.rp];
            n.tmr = CYC_SETUP;
            n.fsm = S_SETUP;
          end else if (eng_rev && !q.cab_s2.ack_n && !push &&
                       !q_full(q.cnt)) begin
            push = 1'b1;
            pdat = {~q.cab_s2.busy, q.cab_s2.pd};
            n.fsm = S_REV_HI;
          end
        end
        S_SETUP: begin
          if (q.tmr <= 8'h01) begin
            n.tmr = CYC_PULSE;
            n.fsm = S_PULSE;
          end else begin
            n.tmr = q.tmr - 8'h01;
          end
        end
        S_PULSE: begin
          if (q.tmr > 8'h01) begin
            n.tmr = q.tmr - 8'h01;
          end else if (q.mode == MODE_FIFO) begin
            n.fsm = S_IDLE;
          end else begin
            n.fsm = S_WAIT_HI;
          end
        end
        // ecp strobe held until busy answers
        S_WAIT_HI: if (q.cab_s2.busy) n.fsm = S_WAIT_LO;
        S_WAIT_LO: if (!q.cab_s2.busy) n.fsm = S_IDLE;
        S_REV_HI: if (q.cab_s2.ack_n) n.fsm = S_IDLE;
        default: n.fsm = S_IDLE;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // shared queue; full drops, empty repeats
    // four-bit pointers wrap at the depth
    if (push && !q_full(q.cnt)) begin
      n.mem[q.wp] = pdat;
      n.wp = q.wp + 4'h1;
    end else begin
      push = 1'b0;
    end
    if (pop) begin
      n.rp = q.rp + 4'h1;
      n.last = q.mem[q.rp][7:0];
    end
    n.cnt = q.cnt + {4'h0, push} - {4'h0, pop};
    if (q.mode == MODE_SPP) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = 5'h00;
    end

    // service flag: hardware set beats a software clear
    if (!q.dma_en && (eng_fwd || eng_rev || q.mode == MODE_TEST)) begin
      if ((!dir && free >= FREE_SPACE_LEVEL) ||
          (dir && q.cnt >= FILL_LEVEL_TRIGGER)) begin
        n.svc = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////
    // cable outputs
    n.co.init_n = q.ctrl[CB_INIT];
    n.co.printer_select_out = ~q.ctrl[CB_SEL];
    if (eng_fwd) begin
      drive = (q.fsm == S_PULSE) | (q.fsm == S_WAIT_HI);
      n.co.strobe_n = ~drive;
      n.co.line_feed_out = (q.mode == MODE_ECP) ? ~q.byte_q[8] :
                           ~q.ctrl[CB_LF];
      n.co.pd_out = q.byte_q[7:0];
    end else if (eng_rev) begin
      n.co.strobe_n = ~q.ctrl[CB_STB];
      // host ack high until the peripheral releases ack
      n.co.line_feed_out = (q.fsm == S_REV_HI);
      n.co.pd_out = q.data;
    end else begin
      n.co.strobe_n = ~q.ctrl[CB_STB];
      n.co.line_feed_out = ~q.ctrl[CB_LF];
      n.co.pd_out = (q.mode == MODE_TEST) ? head : q.data;
    end
    if (q.mode == MODE_SPP) begin
      n.co.strobe_oe = ~n.co.strobe_n;
      n.co.line_feed_oe = ~n.co.line_feed_out;
      n.co.init_oe = ~n.co.init_n;
      n.co.select_oe = ~n.co.printer_select_out;
    end else begin
      n.co.strobe_oe = 1'b1;
      n.co.line_feed_oe = 1'b1;
      n.co.init_oe = 1'b1;
      n.co.select_oe = 1'b1;
    end
    // data drivers ignore direction in 000 and 010
    n.co.pd_oe = (q.mode == MODE_SPP) | (q.mode == MODE_FIFO) | ~dir;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      // pins and strobes idle high in reset
      q.host_s1 <= '1;
      q.host_s2 <= '1;
      q.cab_s1 <= '1;
      q.cab_s2 <= '1;
      q.ack_prev <= 1'b1;
      q.ctrl <= CTRL_RESET;
      q.mode <= MODE_RESET;
      q.err_dis <= ERRDIS_RESET;
      q.svc <= SVC_RESET;
      q.fsm <= S_IDLE;
      q.co <= CO_RESET;
    end else begin
      q <= n;
    end
  end

endmodule

// file: tb/ecp_printer_port_regs_fifo_tb.sv
// self-checking bench for the printer port block
`timescale 1ns/1ps
`define CHECK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module ecp_printer_port_regs_fifo_tb;
  import epprf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  epprf_host_type host;
  logic irq_line_in = 1'b0;
  logic [7:0] db_out;
  logic db_oe;
  logic irq_out;
  epprf_cable_in_type cable_in;
  epprf_cable_out_type cable_out;
  logic [3:0] stat_in = 4'h0;
  logic [7:0] last_byte, byte_count, rd, n0;
  logic last_tag;
  logic [3:0] sv[2] = '{4'hA, 4'h5};
  logic [7:0] cv[3] = '{8'hFF, 8'h06, 8'h09};
  logic [7:0] bv[4] = '{8'hFF, 8'h03, 8'h0A, 8'h01};
  logic [7:0] be[4] = '{8'h78, 8'h43, 8'h4A, 8'h01};
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int irq_n = 0;
  int irq0;
  epprf_port dut_u (.clk(clk), .rst_n(rst_n), .host(host),
    .irq_line_in(irq_line_in), .db_out(db_out), .db_oe(db_oe),
    .irq_out(irq_out), .cable_in(cable_in), .cable_out(cable_out));
  epprf_printer_model prn_u (.clk(clk), .rst_n(rst_n),
    .cable_out(cable_out), .stat_in(stat_in), .cable_in(cable_in),
    .last_byte(last_byte), .byte_count(byte_count), .last_tag(last_tag));
  initial begin
    forever #2.5 clk = ~clk;
  end
  //////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (irq_out === 1'b1) begin
      irq_n <= irq_n + 1;
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // strobe held five cycles, then five idle
  task automatic acc(input logic [10:0] off, input logic wr,
                     input logic [7:0] wd);
    @(negedge clk);
    host.cs_n = 1'b0;
    host.a10 = off[10];
    host.addr = off[2:0];
    host.db = wd;
    host.iow_n = ~wr;
    host.ior_n = wr;
    repeat (5) @(negedge clk);
    rd = db_out;
    host.cs_n = 1'b1;
    host.iow_n = 1'b1;
    host.ior_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask
  task automatic wr(input logic [10:0] off, input logic [7:0] d);
    acc(off, 1'b1, d);
  endtask
  task automatic chk(input logic [10:0] off, input logic [7:0] e);
    acc(off, 1'b0, 8'h00);
    `CHECK(rd, e)
  endtask
  //////////////////////////////////////////////////
  initial begin
    host = '1;
    host.aen = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk(OFF_CONTROL, 8'h00);
    chk(OFF_EXTCTL, 8'h15);
    foreach (sv[i]) begin
      stat_in = sv[i];
      n0 = {~sv[i][3], 1'b1, sv[i][1], sv[i][2], sv[i][0], 3'b000};
      chk(OFF_STATUS, n0);
    end
    foreach (cv[i]) begin
      wr(OFF_CONTROL, cv[i]);
      chk(OFF_CONTROL, cv[i] & 8'h3F);
      `CHECK(cable_out.printer_select_out, ~cv[i][3])
      `CHECK(cable_out.init_n, cv[i][2])
      `CHECK({cable_out.line_feed_out, cable_out.strobe_n}, ~cv[i][1:0])
    end
    wr(OFF_CONTROL, 8'h20);
    `CHECK(cable_out.pd_oe, 1'b1)
    wr(OFF_EXTCTL, 8'h20);
    `CHECK(cable_out.pd_oe, 1'b0)
    `CHECK(cable_out.strobe_oe, 1'b1)
    wr(OFF_EXTCTL, 8'hA0);
    `CHECK(cable_out.strobe_oe, 1'b1)
    wr(OFF_EXTCTL, 8'hE0);
    chk(OFF_QUEUE, 8'h10);
    foreach (bv[i]) begin
      irq_line_in = (i < 3);
      wr(OFF_RESSEL, bv[i]);
      chk(OFF_RESSEL, be[i]);
    end
    wr(OFF_EXTCTL, 8'h00);
    `CHECK(cable_out.strobe_oe, 1'b0)
    wr(OFF_EXTCTL, 8'hC0);
    for (int i = 0; i < 17; i++) begin
      wr(OFF_QUEUE, 8'hA0 + 8'(i));
      if (i == 6) begin
        chk(OFF_EXTCTL, 8'hC0);
      end else if (i == 7) begin
        chk(OFF_EXTCTL, 8'hC4);
      end
    end
    chk(OFF_EXTCTL, 8'hC6);
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_EXTCTL, 8'hC0);
    chk(OFF_EXTCTL, 8'hC2);
    for (int i = 0; i < 17; i++) begin
      chk(OFF_QUEUE, 8'hA0 + 8'((i > 15) ? 15 : i));
      if (i == 6) begin
        chk(OFF_EXTCTL, 8'hC0);
      end else if (i == 7) begin
        chk(OFF_EXTCTL, 8'hC4);
      end
    end
    chk(OFF_EXTCTL, 8'hC5);
    wr(OFF_EXTCTL, 8'h00);
    wr(OFF_CONTROL, 8'h10);
    wr(OFF_EXTCTL, 8'h40);
    n0 = byte_count;
    irq0 = irq_n;
    wr(OFF_QUEUE, 8'h5A);
    wr(OFF_QUEUE, 8'hC3);
    for (int k = 0; k < 3000 && byte_count != n0 + 8'h02; k++) begin
      @(negedge clk);
    end
    repeat (160) @(negedge clk);
    `CHECK(byte_count, n0 + 8'h02)
    `CHECK(last_byte, 8'hC3)
    `CHECK(irq_n - irq0, 2)
    wr(OFF_EXTCTL, 8'h00);
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_EXTCTL, 8'h60);
    n0 = byte_count;
    wr(OFF_DATA, 8'h81);
    wr(OFF_QUEUE, 8'h3C);
    for (int k = 0; k < 3000 && byte_count != n0 + 8'h01; k++) begin
      @(negedge clk);
    end
    `CHECK(last_byte, 8'h81)
    `CHECK(last_tag, 1'b0)
    for (int k = 0; k < 3000 && byte_count != n0 + 8'h02; k++) begin
      @(negedge clk);
    end
    `CHECK(byte_count, n0 + 8'h02)
    `CHECK(last_byte, 8'h3C)
    `CHECK(last_tag, 1'b1)
    stop_test();
  end
endmodule

// file: tb/epprf_port_chk.sv
// pin-level assertions for the printer port block
`timescale 1ns/1ps
module epprf_port_chk #(
  parameter logic [4:0] FREE_SPACE_LEVEL = 5'h08,
  parameter logic [4:0] FILL_LEVEL_TRIGGER = 5'h08
) (
  input wire logic clk,
  input wire logic rst_n,
  input epprf_pkg::epprf_host_type host,
  input wire logic irq_line_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic irq_out,
  input epprf_pkg::epprf_cable_in_type cable_in,
  input epprf_pkg::epprf_cable_out_type cable_out
);
  import epprf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////
  sequence s_rd;
    !host.ior_n && !host.cs_n && !host.aen;
  endsequence
  property p_rd_oe;
    s_rd [*3] |-> db_oe;
  endproperty
  property p_oe_cause;
    db_oe |-> !$past(host.ior_n, 2) && !$past(host.cs_n, 2);
  endproperty
  property p_out_hold;
    !$stable(db_out) |-> $past(db_oe);
  endproperty
  property p_irq_one;
    irq_out |=> !irq_out;
  endproperty
  property p_irq_cause;
    irq_out |-> $past(cable_in.ack_n, 3) && !$past(cable_in.ack_n, 4);
  endproperty
  // a low control line is always actively driven
  property p_drive_low;
    (cable_out.strobe_oe || cable_out.strobe_n) &&
    (cable_out.line_feed_oe || cable_out.line_feed_out) &&
    (cable_out.init_oe || cable_out.init_n) &&
    (cable_out.select_oe || cable_out.printer_select_out);
  endproperty
  property p_pd_hold;
    !cable_out.strobe_n && !$past(cable_out.strobe_n) |->
      $stable(cable_out.pd_out);
  endproperty
  property p_rst_vals;
    $rose(rst_n) |-> !cable_out.init_n && cable_out.strobe_n &&
      cable_out.line_feed_out && cable_out.printer_select_out && !irq_out;
  endproperty
  //////////////////////////////////////////////////
  a_rd_oe: assert property (p_rd_oe) else $error("read not enabled");
  a_oe_cause: assert property (p_oe_cause) else $error("stray read");
  a_out_hold: assert property (p_out_hold) else $error("db moved");
  a_irq_one: assert property (p_irq_one) else $error("long irq");
  a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
  a_drive_low: assert property (p_drive_low) else $error("undriven");
  a_pd_hold: assert property (p_pd_hold) else $error("pd moved");
  a_rst_vals: assert property (p_rst_vals) else $error("reset pins");
endmodule
bind epprf_port epprf_port_chk #(
  .FREE_SPACE_LEVEL(FREE_SPACE_LEVEL),
  .FILL_LEVEL_TRIGGER(FILL_LEVEL_TRIGGER)
) chk_u (.clk(clk), .rst_n(rst_n), .host(host), .irq_line_in(irq_line_in),
  .db_out(db_out), .db_oe(db_oe), .irq_out(irq_out),
  .cable_in(cable_in), .cable_out(cable_out));

// file: tb/epprf_printer_model.sv
// behavioural printer on the far end of the cable
`timescale 1ns/1ps
module epprf_printer_model (
  input wire logic clk,
  input wire logic rst_n,
  input epprf_pkg::epprf_cable_out_type cable_out,
  input wire logic [3:0] stat_in,
  output epprf_pkg::epprf_cable_in_type cable_in,
  output logic [7:0] last_byte,
  output logic [7:0] byte_count,
  output logic last_tag
);
  import epprf_pkg::*;
  logic [7:0] noise_q;
  logic stb_q;
  logic busy_q;
  logic [3:0] wait_q;
  wire stb = !cable_out.strobe_oe || cable_out.strobe_n;
  wire ack_w = !(wait_q != 4'h0 && wait_q < 4'h7);
  // undriven data lines never settle
  wire [7:0] pd_w = cable_out.pd_oe ? cable_out.pd_out : noise_q;
  assign cable_in = {stat_in[3] | busy_q, ack_w, stat_in[1], stat_in[2],
                     stat_in[0], pd_w};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      noise_q <= 8'h00;
      stb_q <= 1'b1;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      last_byte <= 8'h00;
      byte_count <= 8'h00;
      last_tag <= 1'b1;
    end else begin
      noise_q <= noise_q + 8'h5B;
      stb_q <= stb;
      if (stb_q && !stb) begin
        last_byte <= cable_out.pd_out;
        byte_count <= byte_count + 8'h01;
        last_tag <= cable_out.line_feed_out;
        busy_q <= 1'b1;
      end
      if (!stb_q && stb && busy_q) begin
        wait_q <= 4'hC;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      if (wait_q == 4'h1) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule
